// file: rtl/mie_params.svh
// Constants for the instruction execute subset: widths, reset values
// and the software interrupt vector.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH

`define MIE_PC_W 10
`define MIE_DATA_W 8
`define MIE_REG_ADDR_W 6
`define MIE_POINTER_BITS 2
`define MIE_PC_RESET 10'h000
`define MIE_ACC_RESET 8'h00
`define MIE_SWI_VECTOR 10'h001
`define MIE_PC_STEP 10'h001
`define MIE_PC_SKIP_STEP 10'h002

`endif

// file: rtl/mie_pkg.sv
// Types shared by the execute unit, its ALU and the ALU interface.
// Assumes nothing beyond a SystemVerilog compiler.
package mie_pkg;

    // Operation presented with each issued instruction
    typedef enum logic [2:0] {
        MIE_OP_NONE,
        MIE_OP_ENABLE_INTERRUPTS,
        MIE_OP_JUMP_VIA_ACCUMULATOR,
        MIE_OP_INCREMENT_REGISTER,
        MIE_OP_INCREMENT_SKIP_ZERO,
        MIE_OP_OR_ACCUMULATOR_REGISTER,
        MIE_OP_SOFTWARE_INTERRUPT
    } mie_op_t;

    // Issue sequencer states
    typedef enum logic [1:0] {
        ST_EXECUTE,
        ST_STALL_TWO,
        ST_STALL_ONE
    } mie_state_t;

    // ALU function select
    typedef enum logic {
        ALU_INCREMENT,
        ALU_OR
    } mie_alu_sel_t;

endpackage

// file: rtl/mie_alu_if.sv
// Operand and result bundle between the execute unit and its ALU.
// Assumes both ends share DATA_W.
`timescale 1ns/10ps
interface mie_alu_if #(parameter int DATA_W = 8);
    mie_pkg::mie_alu_sel_t sel;
    logic [DATA_W-1:0] reg_operand;
    logic [DATA_W-1:0] acc_operand;
    logic [DATA_W-1:0] result;
    logic zero;

    modport unit (output sel, output reg_operand, output acc_operand,
                  input result, input zero);
    modport alu (input sel, input reg_operand, input acc_operand,
                 output result, output zero);
endinterface

// file: rtl/mie_alu.sv
// Combinational ALU: register increment or accumulator OR register,
// with a zero indication on the 8-bit result.
// Assumes operands are stable within the issuing cycle.
`timescale 1ns/10ps
module mie_alu (
    // Operands and result
    mie_alu_if.alu alu_bus
);
    always_comb begin
        unique case (alu_bus.sel)
            mie_pkg::ALU_INCREMENT: begin
                alu_bus.result = alu_bus.reg_operand + 1'b1;
            end
            mie_pkg::ALU_OR: begin
                alu_bus.result = alu_bus.acc_operand | alu_bus.reg_operand;
            end
        endcase
    end

    // Zero wrap of 0xFF + 1 lands here as well
    assign alu_bus.zero = (alu_bus.result == '0);
endmodule

// file: rtl/mie_exec_unit.sv
// Execute unit for a subset of an 8-bit core's instructions.
// Assumes the register file answers reg_rdata_i for reg_addr_i in the
// same cycle and forwards its own pending write.
//
// Overview of operation
// - Enable-interrupts sets the global interrupt enable to one.
// - Jump loads pointer bits 1:0 and accumulator into PC; 2 cycles.
// - Increment adds one into accumulator or register by select; Z; 1 cycle.
// - Software interrupt pushes PC+1, loads 0x001 into PC, takes 3 cycles.
// - Increment-skip-zero increments first, stores by destination select.
// - Zero result discards the fetched next instruction; takes 2 cycles.
// - OR accumulator with register into chosen destination; Z; 1 cycle.
`timescale 1ns/10ps
`include "mie_params.svh"
module mie_exec_unit #(
    parameter int PC_W = `MIE_PC_W,
    parameter int DATA_W = `MIE_DATA_W,
    parameter int REG_ADDR_W = `MIE_REG_ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Instruction issue
    input wire logic exec_valid_i,
    output logic exec_ready_o,
    input wire mie_pkg::mie_op_t op_i,
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic dest_sel_i,
    input wire logic [DATA_W-1:0] table_high_pointer_i,
    // Register file
    input wire logic [DATA_W-1:0] reg_rdata_i,
    output logic reg_we_o,
    output logic [REG_ADDR_W-1:0] reg_waddr_o,
    output logic [DATA_W-1:0] reg_wdata_o,
    // Return stack
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_data_o,
    // Core state
    output logic [PC_W-1:0] program_counter_o,
    output logic [DATA_W-1:0] accumulator_o,
    output logic zero_flag_o,
    output logic global_interrupt_enable_o,
    output logic discard_fetch_o
);

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Jump target is exactly two pointer bits above one accumulator
    if (PC_W != `MIE_POINTER_BITS + DATA_W) begin : g_bad_pc_w
        $error("PC_W must equal pointer bits plus DATA_W");
    end
    if (DATA_W != 8 || REG_ADDR_W < 1) begin : g_bad_data_w
        $error("DATA_W must be 8 and REG_ADDR_W at least 1");
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic writes_result(input mie_pkg::mie_op_t op);
        return op == mie_pkg::MIE_OP_INCREMENT_REGISTER ||
               op == mie_pkg::MIE_OP_INCREMENT_SKIP_ZERO ||
               op == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER;
    endfunction

    function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc,
                                               input logic [PC_W-1:0] n);
        return PC_W'(pc + n);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Issue and ALU

    mie_pkg::mie_state_t state_reg;
    logic [PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] acc_reg;
    logic issue;
    logic skip;

    mie_alu_if #(.DATA_W(DATA_W)) alu_bus ();

    mie_alu u_alu (
        .alu_bus(alu_bus)
    );

    assign exec_ready_o = (state_reg == mie_pkg::ST_EXECUTE);
    assign issue = exec_valid_i && exec_ready_o;
    assign alu_bus.sel = (op_i == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER)
                         ? mie_pkg::ALU_OR : mie_pkg::ALU_INCREMENT;
    assign alu_bus.reg_operand = reg_rdata_i;
    assign alu_bus.acc_operand = acc_reg;
    assign skip = issue && op_i == mie_pkg::MIE_OP_INCREMENT_SKIP_ZERO &&
                  alu_bus.zero;

    ////////////////////////////////////////////////////////////////////
    // Sequencer: holds issue off for the extra cycles of long ops

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= mie_pkg::ST_EXECUTE;
        end else begin
            unique case (state_reg)
                mie_pkg::ST_EXECUTE: begin
                    if (issue &&
                        op_i == mie_pkg::MIE_OP_SOFTWARE_INTERRUPT) begin
                        state_reg <= mie_pkg::ST_STALL_TWO;
                    end else if (issue && (skip || op_i ==
                                 mie_pkg::MIE_OP_JUMP_VIA_ACCUMULATOR)) begin
                        state_reg <= mie_pkg::ST_STALL_ONE;
                    end
                end
                mie_pkg::ST_STALL_TWO: begin
                    state_reg <= mie_pkg::ST_STALL_ONE;
                end
                mie_pkg::ST_STALL_ONE: begin
                    state_reg <= mie_pkg::ST_EXECUTE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program counter

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pc_reg <= `MIE_PC_RESET;
        end else if (issue) begin
            unique case (op_i)
                mie_pkg::MIE_OP_JUMP_VIA_ACCUMULATOR: begin
                    pc_reg <= {table_high_pointer_i[`MIE_POINTER_BITS-1:0],
                               acc_reg};
                end
                mie_pkg::MIE_OP_SOFTWARE_INTERRUPT: begin
                    pc_reg <= `MIE_SWI_VECTOR;
                end
                mie_pkg::MIE_OP_INCREMENT_SKIP_ZERO: begin
                    // Skipped slot runs as a NOP, so step over it
                    pc_reg <= pc_add(pc_reg, skip ? `MIE_PC_SKIP_STEP
                                                  : `MIE_PC_STEP);
                end
                default: begin
                    pc_reg <= pc_add(pc_reg, `MIE_PC_STEP);
                end
            endcase
        end
    end

    assign program_counter_o = pc_reg;

    ////////////////////////////////////////////////////////////////////
    // Accumulator, register write-back, zero flag

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            acc_reg <= `MIE_ACC_RESET;
        end else if (issue && writes_result(op_i) && !dest_sel_i) begin
            acc_reg <= alu_bus.result;
        end
    end

    assign accumulator_o = acc_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_we_o <= 1'b0;
            reg_waddr_o <= '0;
            reg_wdata_o <= '0;
        end else begin
            reg_we_o <= issue && writes_result(op_i) &&
                        dest_sel_i;
            reg_waddr_o <= reg_addr_i;
            reg_wdata_o <= alu_bus.result;
        end
    end

    // Skip-on-zero leaves the flag alone
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            zero_flag_o <= 1'b0;
        end else if (issue &&
                     (op_i == mie_pkg::MIE_OP_INCREMENT_REGISTER ||
                      op_i == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER)) begin
            zero_flag_o <= alu_bus.zero;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt enable, stack push, fetch discard

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            global_interrupt_enable_o <= 1'b0;
        end else if (issue &&
                     op_i == mie_pkg::MIE_OP_ENABLE_INTERRUPTS) begin
            global_interrupt_enable_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            stack_push_o <= 1'b0;
            stack_data_o <= '0;
            discard_fetch_o <= 1'b0;
        end else begin
            stack_push_o <= issue &&
                            op_i == mie_pkg::MIE_OP_SOFTWARE_INTERRUPT;
            stack_data_o <= pc_add(pc_reg, `MIE_PC_STEP);
            discard_fetch_o <= skip;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    int_enable_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_ENABLE_INTERRUPTS
        |=> global_interrupt_enable_o [*2])
        else $error("interrupt enable not set");

    jump_target_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_JUMP_VIA_ACCUMULATOR
        |=> program_counter_o == {$past(table_high_pointer_i[1:0]),
                                  $past(acc_reg)}
            && !exec_ready_o ##1 exec_ready_o)
        else $error("jump target or length wrong");

    inc_dest_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_INCREMENT_REGISTER && !dest_sel_i
        |=> accumulator_o == DATA_W'($past(reg_rdata_i) + 1'b1)
            && !reg_we_o && exec_ready_o)
        else $error("increment to accumulator wrong");

    reg_write_a: assert property (
        issue && writes_result(op_i) && dest_sel_i
        |=> reg_we_o && reg_waddr_o == $past(reg_addr_i)
            && accumulator_o == $past(acc_reg))
        else $error("register write-back wrong");

    swi_push_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_SOFTWARE_INTERRUPT
        |=> stack_push_o && stack_data_o == PC_W'($past(pc_reg) + 1'b1)
            && program_counter_o == 10'h001
            ##0 !exec_ready_o [*2] ##1 exec_ready_o)
        else $error("software interrupt wrong");

    skip_zero_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_INCREMENT_SKIP_ZERO
        |=> discard_fetch_o == ($past(reg_rdata_i) == 8'hFF)
            && exec_ready_o == !discard_fetch_o
            && program_counter_o == PC_W'($past(pc_reg) +
                                          (discard_fetch_o ? 2 : 1)))
        else $error("skip on zero wrong");

    or_result_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER
        |=> ($past(dest_sel_i) ? reg_wdata_o : accumulator_o)
            == ($past(acc_reg) | $past(reg_rdata_i)))
        else $error("or result wrong");

    // Reset clears the flag too, so only edges after a live cycle count
    zero_flag_a: assert property (
        $changed(zero_flag_o) && $past(rst_b_i)
        |-> $past(issue) && zero_flag_o == ($past(alu_bus.result) == 8'h00))
        else $error("zero flag wrong");

    zero_update_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_INCREMENT_REGISTER
        |=> zero_flag_o == ($past(reg_rdata_i) == 8'hFF))
        else $error("increment zero flag wrong");

    or_zero_a: assert property (
        issue && op_i == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER
        |=> zero_flag_o == (($past(acc_reg) | $past(reg_rdata_i)) == 8'h00))
        else $error("or zero flag wrong");

    jump_cov: cover property (
        issue && op_i == mie_pkg::MIE_OP_JUMP_VIA_ACCUMULATOR);
    swi_cov: cover property (
        issue && op_i == mie_pkg::MIE_OP_SOFTWARE_INTERRUPT);
    skip_cov: cover property (skip);
    or_reg_cov: cover property (
        issue && op_i == mie_pkg::MIE_OP_OR_ACCUMULATOR_REGISTER
        && dest_sel_i);

endmodule

// file: tb/mie_regfile_model.sv
// Register file model facing the execute unit.
// Assumes at most one write per cycle and a combinational read.
`timescale 1ns/10ps
module mie_regfile_model (
    // Clock
    input wire logic clk_i,
    // Read port
    input wire logic [5:0] raddr_i,
    output logic [7:0] rdata_o,
    // Write port
    input wire logic we_i,
    input wire logic [5:0] waddr_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem [64];

    // Pending write forwarded, write-back lands a cycle after issue
    assign rdata_o = (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule

// file: tb/mcu_instruction_execute_subset_bench.sv
// Self-checking bench for the execute unit and a register file model.
// Assumes the design files and the model are compiled ahead of it.
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: %s", $time, m); end end
module mcu_instruction_execute_subset_bench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic exec_valid_i = 1'b0;
    mie_pkg::mie_op_t op_i = mie_pkg::MIE_OP_NONE;
    logic [5:0] reg_addr_i = 6'h00;
    logic dest_sel_i = 1'b0;
    logic [7:0] table_high_pointer_i = 8'h00;
    logic [7:0] reg_rdata_i, reg_wdata_o, accumulator_o;
    logic [5:0] reg_waddr_o;
    logic [9:0] stack_data_o, program_counter_o;
    logic exec_ready_o, reg_we_o, stack_push_o, zero_flag_o;
    logic global_interrupt_enable_o, discard_fetch_o;
    logic [9:0] e_pc;
    logic [7:0] e_acc;
    logic e_z, e_ien;
    logic [7:0] mirror [64];
    int errors = 0;
    int n_tests = 0;

    always #4 clk_i = ~clk_i;

    mie_exec_unit dut_u (.clk_i, .rst_b_i, .exec_valid_i, .exec_ready_o,
        .op_i, .reg_addr_i, .dest_sel_i, .table_high_pointer_i,
        .reg_rdata_i, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .stack_push_o,
        .stack_data_o, .program_counter_o, .accumulator_o, .zero_flag_o,
        .global_interrupt_enable_o, .discard_fetch_o);

    mie_regfile_model rf_u (.clk_i(clk_i), .raddr_i(reg_addr_i),
        .rdata_o(reg_rdata_i), .we_i(reg_we_o), .waddr_i(reg_waddr_o),
        .wdata_i(reg_wdata_o));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] calc(input logic [2:0] c,
                                        input logic [7:0] acc,
                                        input logic [7:0] r);
        return (c == 3'h5) ? (acc | r) : r + 8'h01;
    endfunction

    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic state_chk();
        `CHK({program_counter_o, accumulator_o, zero_flag_o,
              global_interrupt_enable_o}, {e_pc, e_acc, e_z, e_ien},
             "core state")
    endtask

    task automatic setr(input logic [5:0] a, input logic [7:0] v);
        mirror[a] = v;
        rf_u.mem[a] = v;
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        exec_valid_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        {e_pc, e_acc, e_z, e_ien} = 20'h00000;
        state_chk();
        `CHK({exec_ready_o, reg_we_o, stack_push_o, discard_fetch_o},
             4'h8, "reset outputs")
    endtask

    // Request held through the stall so a wrongly taken repeat shows
    task automatic run_op(input logic [2:0] c, input logic [5:0] a,
                          input logic d, input logic [7:0] tb);
        logic [7:0] res;
        logic [9:0] p;
        logic wr;
        logic skip;
        int stall;
        res = calc(c, e_acc, mirror[a]);
        p = e_pc;
        wr = 1'b0;
        skip = 1'b0;
        stall = 0;
        @(posedge clk_i);
        exec_valid_i <= 1'b1;
        op_i <= mie_pkg::mie_op_t'(c);
        reg_addr_i <= a;
        dest_sel_i <= d;
        table_high_pointer_i <= tb;
        e_pc = p + 10'h001;
        case (c)
            3'h1: e_ien = 1'b1;
            3'h2: begin
                e_pc = {tb[1:0], e_acc};
                stall = 1;
            end
            3'h6: begin
                e_pc = 10'h001;
                stall = 2;
            end
            3'h3, 3'h5: e_z = (res == 8'h00);
            3'h4: begin
                if (res == 8'h00) begin
                    skip = 1'b1;
                    stall = 1;
                    e_pc = p + 10'h002;
                end
            end
            default: ;
        endcase
        if (c >= 3'h3 && c <= 3'h5) begin
            if (d) begin
                wr = 1'b1;
                mirror[a] = res;
            end else begin
                e_acc = res;
            end
        end
        @(posedge clk_i);
        if (stall == 0) exec_valid_i <= 1'b0;
        #1;
        state_chk();
        `CHK(exec_ready_o, stall == 0, "ready after issue")
        `CHK(reg_we_o, wr, "write strobe")
        if (wr) `CHK({reg_waddr_o, reg_wdata_o}, {a, res}, "write")
        `CHK(stack_push_o, c == 3'h6, "push")
        if (c == 3'h6) `CHK(stack_data_o, p + 10'h001, "return")
        `CHK(discard_fetch_o, skip, "discard")
        for (int k = 1; k <= stall; k++) begin
            @(posedge clk_i);
            if (k == stall) exec_valid_i <= 1'b0;
            #1;
            state_chk();
            `CHK({exec_ready_o, stack_push_o, discard_fetch_o, reg_we_o},
                 {k == stall, 3'b000}, "stall")
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge clk_i);
        errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h9c08));
        for (int i = 0; i < 64; i++) begin
            setr(6'(i), 8'($urandom));
        end
        do_reset(10);
        setr(6'h05, 8'hFF);
        run_op(3'h3, 6'h05, 1'b1, 8'h00);
        run_op(3'h4, 6'h05, 1'b0, 8'h00);
        setr(6'h06, 8'hFF);
        run_op(3'h4, 6'h06, 1'b1, 8'h00);
        setr(6'h07, 8'hFF);
        run_op(3'h4, 6'h07, 1'b0, 8'h00);
        run_op(3'h5, 6'h06, 1'b0, 8'h00);
        run_op(3'h5, 6'h05, 1'b1, 8'h00);
        run_op(3'h1, 6'h00, 1'b0, 8'h00);
        run_op(3'h2, 6'h00, 1'b0, 8'hFE);
        run_op(3'h6, 6'h00, 1'b0, 8'h00);
        run_op(3'h0, 6'h00, 1'b0, 8'h00);
        for (int i = 0; i < 300; i++) begin
            if (i == 150) do_reset(2);
            run_op(3'($urandom_range(6, 0)), 6'($urandom), 1'($urandom),
                   8'($urandom));
        end
        end_of_test();
    end
endmodule
